/* include/blkwr_defs.vh */
/*
  Constants for the block-write command engine: register byte offsets,
  field positions, command codes, reset values and sector geometry.
  Assumes a 32-bit APB bus whose registers sit one to an aligned word.
*/
// Operation
// - opcode C5h starts the 28-bit block write
// - opcode 39h starts the 48-bit extended block write
// - accept sectors of host data, then commit each to the media
// - one interrupt per block of the configured multiple count
// - each data register access moves one 16-bit word
// - 28-bit sector count zero means 256 sectors
// - extended count is previous:current bytes, zero means 65536
// - logical mode: sector number holds address bits 7:0
// - logical mode: cylinder low 15:8, cylinder high 23:16
// - logical mode: head bits hold address bits 27:24
// - geometry mode: sector, cylinder and head from their fields
// - on completion sector count shows sectors not written
// - on completion address registers show last sector written
// - extended address spread over current and previous bytes
// - extended error address readable low or high by select bit
// - an uncorrectable sector stops the write there
`ifndef BLKWR_DEFS_VH
`define BLKWR_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_DATA         8'h00
`define OFS_FEATURE_ERR  8'h04
`define OFS_SECT_COUNT   8'h08
`define OFS_SECT_NUMBER  8'h0C
`define OFS_CYL_LOW      8'h10
`define OFS_CYL_HIGH     8'h14
`define OFS_DEVICE_HEAD  8'h18
`define OFS_CMD_STATUS   8'h1C
`define OFS_DEV_CONTROL  8'h20
`define OFS_MULT_COUNT   8'h24
`define OFS_IRQ_STATUS   8'h28
`define OFS_IRQ_MASK     8'h2C

// ----------------------------------------------------------------------------
// command codes and fields
// ----------------------------------------------------------------------------
`define CMD_BLOCK_WRITE      8'hC5
`define CMD_BLOCK_WRITE_EXT  8'h39
`define DH_LBA_BIT           6
`define CTL_HI_SEL_BIT       7
`define ST_BSY 7
`define ST_RDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define IRQ_BLOCK 0
`define IRQ_DONE  1
`define IRQ_FAIL  2
`define IRQ_WIDTH 3

// ----------------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------------
`define COUNT28_ZERO     17'h00100
`define COUNT48_ZERO     17'h10000
`define LAST_WORD        8'hFF
`define SECTORS_PER_TRK  8'h3F
`define LAST_HEAD        4'hF
`define MULT_RESET       8'h10
`define DH_RESET         8'hA0

`endif

/* rtl/taskfile_byte_pair.v */
/*
  One task-file byte with its previous (high order) copy.
  Assumes the core only loads it while the host cannot write it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blkwr_defs.vh"

module taskfile_byte_pair (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  input  wire       load_in,
  input  wire [7:0] load_cur_in,
  input  wire [7:0] load_prev_in,
  input  wire       sel_in,
  output reg  [7:0] cur_out,
  output reg  [7:0] prev_out,
  output wire [7:0] rd_out
);

  // a host write pushes the old byte into the previous slot
  always @(posedge clk_in) begin
    if (rst_in) begin
      cur_out  <= 8'h00;
      prev_out <= 8'h00;
    end else if (ce_in) begin
      if (load_in) begin
        cur_out  <= load_cur_in;
        prev_out <= load_prev_in;
      end else if (wr_in) begin
        prev_out <= cur_out;
        cur_out  <= wdata_in;
      end
    end
  end

  assign rd_out = sel_in ? prev_out : cur_out;

endmodule // taskfile_byte_pair
`default_nettype wire

/* rtl/sticky_irq.v */
/*
  Sticky event flags, write-one-to-clear, with a mask onto one level line.
  Assumes event inputs are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blkwr_defs.vh"

module sticky_irq (
  input  wire                  clk_in,
  input  wire                  rst_in,
  input  wire                  ce_in,
  input  wire [`IRQ_WIDTH-1:0] set_in,
  input  wire                  clr_wr_in,
  input  wire                  mask_wr_in,
  input  wire [`IRQ_WIDTH-1:0] wdata_in,
  output reg  [`IRQ_WIDTH-1:0] status_out,
  output reg  [`IRQ_WIDTH-1:0] mask_out,
  output reg                   irq_out
);

  wire [`IRQ_WIDTH-1:0] clr_bits;
  wire [`IRQ_WIDTH-1:0] next_status;

  // set wins over a clear landing in the same cycle
  assign clr_bits    = clr_wr_in ? wdata_in : {`IRQ_WIDTH{1'b0}};
  assign next_status = (status_out & ~clr_bits) | set_in;

  // line is registered so the top output comes from a flop
  always @(posedge clk_in) begin
    if (rst_in) begin
      status_out <= {`IRQ_WIDTH{1'b0}};
      mask_out   <= {`IRQ_WIDTH{1'b0}};
      irq_out    <= 1'b0;
    end else if (ce_in) begin
      status_out <= next_status;
      if (mask_wr_in) begin
        mask_out <= wdata_in;
      end
      irq_out <= |(next_status & (mask_wr_in ? wdata_in : mask_out));
    end
  end

endmodule // sticky_irq
`default_nettype wire

/* rtl/block_write_engine.v */
/*
  Block-write command engine: APB task-file registers, word intake,
  per-sector media commit and ending status for the 28-bit and 48-bit
  block write commands.
  Assumes the media port answers each commit with one done pulse, and
  that all inputs other than the APB and media signals are same-clock.
*/
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "blkwr_defs.vh"

module block_write_engine (
  input  wire        CORE_CLK_IN,
  input  wire        RST_IN,
  input  wire        CE_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  output wire        INTRQ_OUT,
  output reg  [15:0] MEDIA_WORD_OUT,
  output reg         MEDIA_WORD_VALID_OUT,
  output reg         MEDIA_COMMIT_OUT,
  output reg  [47:0] MEDIA_ADDR_OUT,
  output reg         MEDIA_LBA_MODE_OUT,
  input  wire        MEDIA_DONE_IN,
  input  wire        MEDIA_FAIL_IN
);

  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_XFER   = 3'h1;
  localparam [2:0] S_COMMIT = 3'h2;
  localparam [2:0] S_WAIT   = 3'h3;
  localparam [2:0] S_DONE   = 3'h4;

  reg  [2:0]  state;
  reg  [7:0]  feature;
  reg  [7:0]  device_head;
  reg  [7:0]  dev_control;
  reg  [7:0]  mult_count;
  reg         ext_cmd;
  reg         lba_mode;
  reg  [16:0] remain;
  reg  [47:0] addr;
  reg  [47:0] last_addr;
  reg  [7:0]  words;
  reg  [7:0]  blk_secs;
  reg         sector_not_found_flag;
  reg         command_aborted_flag;
  reg         err_bit;
  reg         ev_block;
  reg         ev_done;
  reg         ev_fail;
  reg  [31:0] next_rdata;
  reg         next_slverr;

  wire [7:0]  sc_cur;
  wire [7:0]  sc_prev;
  wire [7:0]  sn_cur;
  wire [7:0]  sn_prev;
  wire [7:0]  cl_cur;
  wire [7:0]  cl_prev;
  wire [7:0]  ch_cur;
  wire [7:0]  ch_prev;
  wire [7:0]  sc_rd;
  wire [7:0]  sn_rd;
  wire [7:0]  cl_rd;
  wire [7:0]  ch_rd;
  wire [`IRQ_WIDTH-1:0] irq_status;
  wire [`IRQ_WIDTH-1:0] irq_mask;

  // ----------------------------------------------------------------------------
  // apb slave: one wait state so read data and ready come from flops
  // ----------------------------------------------------------------------------
  wire access  = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  wire fire    = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr_fire = fire & PWRITE_IN;
  wire rd_fire = fire & ~PWRITE_IN;
  wire idle    = (state == S_IDLE);
  wire high_byte_readback_select = dev_control[`CTL_HI_SEL_BIT];

  // task-file writes are only honoured while no command runs, except data writes, only in S_XFER, and device control and interrupt writes, at any time
  wire wr_sc   = wr_fire & idle & (PADDR_IN == `OFS_SECT_COUNT);
  wire wr_sn   = wr_fire & idle & (PADDR_IN == `OFS_SECT_NUMBER);
  wire wr_cl   = wr_fire & idle & (PADDR_IN == `OFS_CYL_LOW);
  wire wr_ch   = wr_fire & idle & (PADDR_IN == `OFS_CYL_HIGH);
  wire wr_cmd  = wr_fire & idle & (PADDR_IN == `OFS_CMD_STATUS);
  wire wr_data = wr_fire & (state == S_XFER) & (PADDR_IN == `OFS_DATA);

  wire [7:0] status_byte;
  wire [7:0] error_byte;

  assign status_byte = {~idle, 1'b1, 1'b0, 1'b1, (state == S_XFER), 1'b0, 1'b0, err_bit};
  assign error_byte  = {3'b000, sector_not_found_flag, 1'b0, command_aborted_flag, 2'b00};

  // read mux; unmapped offsets answer zero with an error flag
  always @* begin
    next_rdata  = 32'h00000000;
    next_slverr = 1'b0;
    case (PADDR_IN)
      `OFS_DATA:        next_rdata = 32'h00000000;
      `OFS_FEATURE_ERR: next_rdata = {24'h000000, error_byte};
      `OFS_SECT_COUNT:  next_rdata = {24'h000000, sc_rd};
      `OFS_SECT_NUMBER: next_rdata = {24'h000000, sn_rd};
      `OFS_CYL_LOW:     next_rdata = {24'h000000, cl_rd};
      `OFS_CYL_HIGH:    next_rdata = {24'h000000, ch_rd};
      `OFS_DEVICE_HEAD: next_rdata = {24'h000000, device_head};
      `OFS_CMD_STATUS:  next_rdata = {24'h000000, status_byte};
      `OFS_DEV_CONTROL: next_rdata = {24'h000000, dev_control};
      `OFS_MULT_COUNT:  next_rdata = {24'h000000, mult_count};
      `OFS_IRQ_STATUS:  next_rdata = {29'h00000000, irq_status};
      `OFS_IRQ_MASK:    next_rdata = {29'h00000000, irq_mask};
      default:          next_slverr = 1'b1;
    endcase
  end

  // ready rises for exactly one cycle, one edge after the access phase opens
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
    end else if (CE_IN) begin
      PREADY_OUT  <= access;
      PSLVERR_OUT <= access & next_slverr;
      if (access) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------------------
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      feature     <= 8'h00;
      device_head <= `DH_RESET;
      dev_control <= 8'h00;
      mult_count  <= `MULT_RESET;
    end else if (CE_IN) begin
      if (wr_fire & idle & (PADDR_IN == `OFS_FEATURE_ERR)) begin
        feature <= PWDATA_IN[7:0];
      end
      if (wr_fire & idle & (PADDR_IN == `OFS_DEVICE_HEAD)) begin
        device_head <= PWDATA_IN[7:0];
      end else if (state == S_DONE && !ext_cmd) begin
        device_head <= {device_head[7:4], last_addr[27:24]};
      end
      if (wr_fire & (PADDR_IN == `OFS_DEV_CONTROL)) begin
        dev_control <= PWDATA_IN[7:0];
      end
      if (wr_fire & idle & (PADDR_IN == `OFS_MULT_COUNT)) begin
        mult_count <= PWDATA_IN[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // start address and count decode
  // ----------------------------------------------------------------------------
  wire [15:0] count16 = {sc_prev, sc_cur};
  wire [16:0] count28 = (sc_cur == 8'h00) ? `COUNT28_ZERO : {9'h000, sc_cur};
  wire [16:0] count48 = (count16 == 16'h0000) ? `COUNT48_ZERO : {1'b0, count16};
  // 28-bit start, same packing for geometry fields
  wire [47:0] start28 = {20'h00000, device_head[3:0], ch_cur, cl_cur, sn_cur};
  // 48-bit start from both byte halves
  wire [47:0] start48 = {ch_prev, cl_prev, sn_prev, ch_cur, cl_cur, sn_cur};

  // geometry stepping: sector 1..max, then head, then cylinder
  function [47:0] step_addr;
    input [47:0] a;
    input        lba;
    begin
      step_addr = a + 48'h000000000001;
      if (!lba) begin
        if (a[7:0] != `SECTORS_PER_TRK) begin
          step_addr = {a[47:8], a[7:0] + 8'h01};
        end else if (a[27:24] != `LAST_HEAD) begin
          step_addr = {a[47:28], a[27:24] + 4'h1, a[23:8], 8'h01};
        end else begin
          step_addr = {a[47:28], 4'h0, a[23:8] + 16'h0001, 8'h01};
        end
      end
    end
  endfunction

  wire [7:0] next_blk = blk_secs + 8'h01;

  // ----------------------------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------------------------
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      state                <= S_IDLE;
      ext_cmd              <= 1'b0;
      lba_mode             <= 1'b0;
      remain               <= 17'h00000;
      addr                 <= 48'h000000000000;
      last_addr            <= 48'h000000000000;
      words                <= 8'h00;
      blk_secs             <= 8'h00;
      sector_not_found_flag <= 1'b0;
      command_aborted_flag <= 1'b0;
      err_bit              <= 1'b0;
      ev_block             <= 1'b0;
      ev_done              <= 1'b0;
      ev_fail              <= 1'b0;
      MEDIA_WORD_OUT       <= 16'h0000;
      MEDIA_WORD_VALID_OUT <= 1'b0;
      MEDIA_COMMIT_OUT     <= 1'b0;
      MEDIA_ADDR_OUT       <= 48'h000000000000;
      MEDIA_LBA_MODE_OUT   <= 1'b0;
    end else if (CE_IN) begin
      MEDIA_WORD_VALID_OUT <= 1'b0;
      MEDIA_COMMIT_OUT     <= 1'b0;
      ev_block             <= 1'b0;
      ev_done              <= 1'b0;
      ev_fail              <= 1'b0;
      case (state)
        S_IDLE: begin
          if (wr_cmd) begin
            sector_not_found_flag <= 1'b0;
            command_aborted_flag <= 1'b0;
            err_bit <= 1'b0;
            if ((PWDATA_IN[7:0] == `CMD_BLOCK_WRITE ||
                 PWDATA_IN[7:0] == `CMD_BLOCK_WRITE_EXT) && mult_count != 8'h00) begin
              ext_cmd  <= (PWDATA_IN[7:0] == `CMD_BLOCK_WRITE_EXT);
              lba_mode <= (PWDATA_IN[7:0] == `CMD_BLOCK_WRITE_EXT) |
                          device_head[`DH_LBA_BIT];
              remain   <= (PWDATA_IN[7:0] == `CMD_BLOCK_WRITE_EXT) ? count48 : count28;
              addr     <= (PWDATA_IN[7:0] == `CMD_BLOCK_WRITE_EXT) ? start48 : start28;
              words    <= 8'h00;
              blk_secs <= 8'h00;
              state    <= S_XFER;
            end else begin
              // unknown opcode or no block size set
              command_aborted_flag <= 1'b1;
              err_bit <= 1'b1;
              ev_done <= 1'b1;
              ev_fail <= 1'b1;
            end
          end
        end
        S_XFER: begin
          // forward each word to the media
          if (wr_data) begin
            MEDIA_WORD_OUT       <= PWDATA_IN[15:0];
            MEDIA_WORD_VALID_OUT <= 1'b1;
            words                <= words + 8'h01;
            if (words == `LAST_WORD) begin
              state <= S_COMMIT;
            end
          end
        end
        S_COMMIT: begin
          MEDIA_COMMIT_OUT   <= 1'b1;
          MEDIA_ADDR_OUT     <= addr;
          MEDIA_LBA_MODE_OUT <= lba_mode;
          state              <= S_WAIT;
        end
        S_WAIT: begin
          if (MEDIA_DONE_IN) begin
            last_addr <= addr;
            if (MEDIA_FAIL_IN) begin
              sector_not_found_flag <= 1'b1;
              err_bit <= 1'b1;
              ev_fail <= 1'b1;
              state   <= S_DONE;
            end else begin
              remain <= remain - 17'h00001;
              addr   <= step_addr(addr, lba_mode);
              if (remain == 17'h00001) begin
                state <= S_DONE;
              end else if (next_blk == mult_count) begin
                blk_secs <= 8'h00;
                ev_block <= 1'b1;
                state    <= S_XFER;
              end else begin
                blk_secs <= next_blk;
                state    <= S_XFER;
              end
            end
          end
        end
        S_DONE: begin
          // registers loaded here; raise the ending interrupt
          ev_done <= 1'b1;
          state   <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // task-file byte pairs, loaded with the ending values
  // ----------------------------------------------------------------------------
  wire load_end = CE_IN & (state == S_DONE);

  taskfile_byte_pair u_sect_count (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .wr_in        (wr_sc),
    .wdata_in     (PWDATA_IN[7:0]),
    .load_in      (load_end),
    .load_cur_in  (remain[7:0]),
    .load_prev_in (remain[15:8]),
    .sel_in       (high_byte_readback_select),
    .cur_out      (sc_cur),
    .prev_out     (sc_prev),
    .rd_out       (sc_rd)
  );

  // ending address, split over current and previous bytes
  taskfile_byte_pair u_sect_number (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .wr_in        (wr_sn),
    .wdata_in     (PWDATA_IN[7:0]),
    .load_in      (load_end),
    .load_cur_in  (last_addr[7:0]),
    .load_prev_in (last_addr[31:24]),
    .sel_in       (high_byte_readback_select),
    .cur_out      (sn_cur),
    .prev_out     (sn_prev),
    .rd_out       (sn_rd)
  );

  taskfile_byte_pair u_cyl_low (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .wr_in        (wr_cl),
    .wdata_in     (PWDATA_IN[7:0]),
    .load_in      (load_end),
    .load_cur_in  (last_addr[15:8]),
    .load_prev_in (last_addr[39:32]),
    .sel_in       (high_byte_readback_select),
    .cur_out      (cl_cur),
    .prev_out     (cl_prev),
    .rd_out       (cl_rd)
  );

  taskfile_byte_pair u_cyl_high (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .wr_in        (wr_ch),
    .wdata_in     (PWDATA_IN[7:0]),
    .load_in      (load_end),
    .load_cur_in  (last_addr[23:16]),
    .load_prev_in (last_addr[47:40]),
    .sel_in       (high_byte_readback_select),
    .cur_out      (ch_cur),
    .prev_out     (ch_prev),
    .rd_out       (ch_rd)
  );

  // ----------------------------------------------------------------------------
  // interrupt flags: block request, completion, failure
  // ----------------------------------------------------------------------------
  sticky_irq u_irq (
    .clk_in     (CORE_CLK_IN),
    .rst_in     (RST_IN),
    .ce_in      (CE_IN),
    .set_in     ({ev_fail, ev_done, ev_block}),
    .clr_wr_in  (wr_fire & (PADDR_IN == `OFS_IRQ_STATUS)),
    .mask_wr_in (wr_fire & (PADDR_IN == `OFS_IRQ_MASK)),
    .wdata_in   (PWDATA_IN[`IRQ_WIDTH-1:0]),
    .status_out (irq_status),
    .mask_out   (irq_mask),
    .irq_out    (INTRQ_OUT)
  );

endmodule // block_write_engine
`default_nettype wire

/* sim/media_model.sv */
/* media stand-in: answers each sector commit with one done pulse.
   Assumes the engine holds commit as a one-cycle pulse on clk_in. */
`timescale 1ns/1ps
`default_nettype none
module media_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic commit_in,
  input  wire logic slow_in,
  input  wire logic fail_req_in,
  output logic      done_out,
  output logic      fail_out
);
  logic [4:0] wait_cnt;
  // commit answered; fail only valid with done, toggles otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_cnt <= 5'h00;
      done_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      done_out <= (wait_cnt == 5'h01);
      fail_out <= (wait_cnt == 5'h01) ? fail_req_in : ~fail_out;
      if (commit_in) begin
        wait_cnt <= slow_in ? 5'h14 : 5'h01;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
    end
  end
endmodule // media_model
`default_nettype wire

/* sim/block_write_engine_chk.sv */
/* checker: bus answer timing and media port ordering.
   Assumes CE_IN stays high throughout the run. */
`timescale 1ns/1ps
`default_nettype none
module block_write_engine_chk (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic INTRQ_OUT,
  input wire logic MEDIA_WORD_VALID_OUT,
  input wire logic MEDIA_COMMIT_OUT,
  input wire logic MEDIA_DONE_IN
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [8:0] wcnt;
  logic       pend;
  // words since last commit, and commit awaiting media
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || MEDIA_COMMIT_OUT) begin
      wcnt <= 9'h000;
    end else if (MEDIA_WORD_VALID_OUT) begin
      wcnt <= wcnt + 9'h001;
    end
    pend <= !RST_IN && (MEDIA_COMMIT_OUT || (pend && !MEDIA_DONE_IN));
  end
  sequence s_first_access;
    PSEL_IN && PENABLE_IN && !PREADY_OUT && !$past(PENABLE_IN);
  endsequence
  chk_ready_wait: assert property (s_first_access |=> PREADY_OUT)
    else $error("ready not after one wait");
  chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than a cycle");
  chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  chk_sector_words: assert property (MEDIA_COMMIT_OUT |-> wcnt == 9'h100)
    else $error("commit not after 256 words");
  chk_no_overfill: assert property (MEDIA_WORD_VALID_OUT |-> wcnt < 9'h100)
    else $error("word beyond sector");
  chk_commit_pulse: assert property (MEDIA_COMMIT_OUT |=> !MEDIA_COMMIT_OUT [*4])
    else $error("commit repeated");
  chk_words_wait: assert property (MEDIA_WORD_VALID_OUT |-> !pend)
    else $error("word while media busy");
  chk_irq_fall: assert property ($fell(INTRQ_OUT) |->
    $past(PREADY_OUT && PWRITE_IN, 2) || $past(PREADY_OUT && PWRITE_IN))
    else $error("interrupt dropped without write");
endmodule // block_write_engine_chk
bind block_write_engine block_write_engine_chk chk_i (.CORE_CLK_IN, .RST_IN, .PSEL_IN,
  .PENABLE_IN, .PWRITE_IN, .PREADY_OUT, .PSLVERR_OUT, .INTRQ_OUT, .MEDIA_WORD_VALID_OUT,
  .MEDIA_COMMIT_OUT, .MEDIA_DONE_IN);
`default_nettype wire

/* sim/block_write_engine_test.sv */
/* testbench: apb host driving block writes into the engine.
   Assumes media_model stands on the media port. */
`timescale 1ns/1ps
`default_nettype none
`include "blkwr_defs.vh"
module block_write_engine_test;
  logic clk, rst, psel, pen, pwr, done, fail, slow, freq;
  logic pready, pslverr, irq, wvalid, commit, lba, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] word, wexp, wnext;
  logic [47:0] maddr;
  logic [48:0] cq[$];
  logic [48:0] ce[5];
  int err_count, comparisons;
  block_write_engine uut (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .INTRQ_OUT(irq),
    .MEDIA_WORD_OUT(word), .MEDIA_WORD_VALID_OUT(wvalid), .MEDIA_COMMIT_OUT(commit),
    .MEDIA_ADDR_OUT(maddr), .MEDIA_LBA_MODE_OUT(lba), .MEDIA_DONE_IN(done),
    .MEDIA_FAIL_IN(fail));
  media_model media (.clk_in(clk), .rst_in(rst), .commit_in(commit), .slow_in(slow),
    .fail_req_in(freq), .done_out(done), .fail_out(fail));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [48:0] x, input logic [48:0] g);
    comparisons++;
    if (g !== x) begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      err_count++;
    end
  endtask
  // ------
  // bus cycles: setup, access, hold until ready
  // ------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      cmp("apb_ready", 1, 0);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'hFFFF00, d});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, {41'h0, x}, {41'h0, rdv[7:0]});
  endtask
  // bounded poll of one status bit
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_CMD_STATUS, 32'h0);
      n++;
    end while (rdv[b] !== v && n < 500);
    if (n >= 500) begin
      cmp("status_poll", 1, 0);
      final_report();
    end
  endtask
  // wait for data request, then one sector of words
  task automatic sector();
    poll(3, 1'b1);
    repeat (256) begin
      apb(1'b1, `OFS_DATA, {16'hFFFF, wnext});
      wnext = wnext + 16'h0001;
    end
  endtask
  // each word seen on the media side, and each commit recorded
  always @(posedge clk) begin
    if (wvalid === 1'b1) begin
      cmp("media_word", {33'h0, wexp}, {33'h0, word});
      wexp = wexp + 16'h0001;
    end
    if (commit === 1'b1) cq.push_back({lba, maddr});
  end
  initial begin
    {rst, psel, pen, pwr, slow, freq} = 6'b100000;
    paddr = 8'h00;
    pwdata = 32'h0;
    wexp = 16'h0000;
    wnext = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc(`OFS_DEVICE_HEAD, 8'hA0, "dh_reset");
    rc(`OFS_MULT_COUNT, 8'h10, "mult_reset");
    rc(`OFS_CMD_STATUS, 8'h50, "status_idle");
    apb(1'b0, 8'h30, 32'h0);
    cmp("unmapped_err", 1, errv);
    wr(`OFS_IRQ_MASK, 8'h07);
    // logical 28-bit, block of one sector, two sectors
    wr(`OFS_MULT_COUNT, 8'h01);
    wr(`OFS_SECT_COUNT, 8'h02);
    wr(`OFS_SECT_NUMBER, 8'hEF);
    wr(`OFS_CYL_LOW, 8'hCD);
    wr(`OFS_CYL_HIGH, 8'hBC);
    wr(`OFS_DEVICE_HEAD, 8'hEA);
    wr(`OFS_CMD_STATUS, 8'hC5);
    sector();
    sector();
    poll(7, 1'b0);
    rc(`OFS_SECT_COUNT, 8'h00, "lba_left");
    rc(`OFS_SECT_NUMBER, 8'hF0, "lba_last");
    rc(`OFS_DEVICE_HEAD, 8'hEA, "lba_head");
    rc(`OFS_CMD_STATUS, 8'h50, "lba_status");
    rc(`OFS_FEATURE_ERR, 8'h00, "lba_error");
    rc(`OFS_IRQ_STATUS, 8'h03, "lba_irq");
    cmp("irq_high", 1, irq);
    wr(`OFS_IRQ_STATUS, 8'h07);
    rc(`OFS_IRQ_STATUS, 8'h00, "irq_clear");
    cmp("irq_low", 0, irq);
    // geometry mode across a track end, slow media, one block of two
    slow <= 1'b1;
    wr(`OFS_MULT_COUNT, 8'h02);
    wr(`OFS_SECT_COUNT, 8'h02);
    wr(`OFS_SECT_NUMBER, 8'h3F);
    wr(`OFS_CYL_LOW, 8'h02);
    wr(`OFS_CYL_HIGH, 8'h01);
    wr(`OFS_DEVICE_HEAD, 8'hA3);
    wr(`OFS_CMD_STATUS, 8'hC5);
    sector();
    sector();
    poll(7, 1'b0);
    rc(`OFS_SECT_NUMBER, 8'h01, "chs_sector");
    rc(`OFS_DEVICE_HEAD, 8'hA4, "chs_head");
    rc(`OFS_IRQ_STATUS, 8'h02, "chs_irq");
    wr(`OFS_IRQ_STATUS, 8'h07);
    // extended: high bytes first, media fails on the first sector
    slow <= 1'b0;
    freq <= 1'b1;
    wr(`OFS_SECT_COUNT, 8'h01);
    wr(`OFS_SECT_COUNT, 8'h02);
    wr(`OFS_SECT_NUMBER, 8'h56);
    wr(`OFS_SECT_NUMBER, 8'hBC);
    wr(`OFS_CYL_LOW, 8'h34);
    wr(`OFS_CYL_LOW, 8'h9A);
    wr(`OFS_CYL_HIGH, 8'h12);
    wr(`OFS_CYL_HIGH, 8'h78);
    wr(`OFS_DEVICE_HEAD, 8'hE0);
    wr(`OFS_CMD_STATUS, 8'h39);
    sector();
    poll(7, 1'b0);
    rc(`OFS_CMD_STATUS, 8'h51, "ext_status");
    rc(`OFS_FEATURE_ERR, 8'h10, "ext_error");
    rc(`OFS_SECT_COUNT, 8'h02, "ext_left_lo");
    rc(`OFS_SECT_NUMBER, 8'hBC, "ext_fail_lo");
    wr(`OFS_DEV_CONTROL, 8'h80);
    rc(`OFS_SECT_COUNT, 8'h01, "ext_left_hi");
    rc(`OFS_SECT_NUMBER, 8'h56, "ext_fail_hi");
    rc(`OFS_CYL_HIGH, 8'h12, "ext_cylh_hi");
    wr(`OFS_DEV_CONTROL, 8'h00);
    rc(`OFS_IRQ_STATUS, 8'h06, "ext_irq");
    wr(`OFS_IRQ_STATUS, 8'h07);
    // unknown opcode is refused
    freq <= 1'b0;
    wr(`OFS_CMD_STATUS, 8'h20);
    rc(`OFS_FEATURE_ERR, 8'h04, "abort_error");
    rc(`OFS_CMD_STATUS, 8'h51, "abort_status");
    // addresses handed to the media, in commit order
    ce = '{{1'b1, 48'h00000ABCCDEF}, {1'b1, 48'h00000ABCCDF0}, {1'b0, 48'h00000301023F},
           {1'b0, 48'h000004010201}, {1'b1, 48'h123456789ABC}};
    cmp("commit_count", 49'd5, 49'(cq.size()));
    for (int i = 0; i < 5 && i < cq.size(); i++) cmp("commit_addr", ce[i], cq[i]);
    final_report();
  end
endmodule // block_write_engine_test
`default_nettype wire
